// ---- include/vpf_consts.svh ----
/*
 * Constants of the pixel port formatter: widths, pin fields, clock limits.
 * Assumes inclusion by the formatter package and design files only.
 */
`ifndef VPF_CONSTS_SVH
`define VPF_CONSTS_SVH

// Sample and port widths
`define VPF_SAMPLE_W 12
`define VPF_PORT_W 30
`define VPF_MODE_W 5

// Pin fields of the lower and upper port
`define VPF_HI10 19:10
`define VPF_HI8 19:12
`define VPF_LO10 9:0
`define VPF_LO8 9:2
`define VPF_LO4A 9:6
`define VPF_LO4B 5:2
`define VPF_UP10 29:20
`define VPF_UP8 29:22

// Pixel clock rate and the ceiling for single-lane component modes
`define VPF_CLK_MHZ 50
`define VPF_NARROW_MAX_MHZ 54

`endif

// ---- include/vpf_pkg.sv ----
/*
 * Types of the pixel port formatter: modes, 4:2:2 phases, carriers.
 * Assumes vpf_consts.svh is on the include path.
 */
`include "vpf_consts.svh"

package vpf_pkg;

    // Port mode code, one set per processing path
    typedef logic [`VPF_MODE_W-1:0] vpf_mode_t;

    // Mode numbers; 0 switches the port off
    typedef enum logic [`VPF_MODE_W-1:0]
    {
        VPF_OFF = 5'h00, VPF_M1  = 5'h01, VPF_M2  = 5'h02, VPF_M3  = 5'h03,
        VPF_M4  = 5'h04, VPF_M5  = 5'h05, VPF_M6  = 5'h06, VPF_M7  = 5'h07,
        VPF_M8  = 5'h08, VPF_M9  = 5'h09, VPF_M10 = 5'h0a, VPF_M11 = 5'h0b,
        VPF_M12 = 5'h0c, VPF_M13 = 5'h0d, VPF_M14 = 5'h0e, VPF_M15 = 5'h0f,
        VPF_M16 = 5'h10, VPF_M17 = 5'h11, VPF_M18 = 5'h12, VPF_M19 = 5'h13
    } vpf_mode_e;

    // Processing path feeding the port
    typedef enum logic
    {
        VPF_SD_DECODE_PATH = 1'b0,
        VPF_COMPONENT_PATH = 1'b1
    } vpf_path_e;

    // Single-lane 4:2:2 word order, Gray coded
    typedef enum logic [1:0]
    {
        VPF_PH_CB = 2'b00,
        VPF_PH_Y0 = 2'b01,
        VPF_PH_CR = 2'b11,
        VPF_PH_Y1 = 2'b10
    } vpf_phase_e;

    // One pixel: luma/green, red diff/red, blue diff/blue
    typedef struct packed
    {
        logic [`VPF_SAMPLE_W-1:0] chan_a;
        logic [`VPF_SAMPLE_W-1:0] chan_b;
        logic [`VPF_SAMPLE_W-1:0] chan_c;
    } vpf_pix_s;

    // Timing references travelling with the pixels
    typedef struct packed
    {
        logic line_or_composite_sync;
        logic frame_sync_or_parity;
        logic active_video_or_parity;
    } vpf_ref_s;

endpackage

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the pixel port formatter, with a second copy
 * built above the single-lane clock ceiling.
 * Assumes vpf_pkg and the sink model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import vpf_pkg::*;

    localparam int WD_NS = 20 * 5000; // Run needs about 1000 clocks

    logic        clk_sys_i;        // Pixel clock
    logic        nrst_i;           // Reset, active low
    vpf_path_e   path;             // Path driven
    vpf_mode_t   mode;             // Mode driven
    vpf_pix_s    pix;              // Pixel driven
    vpf_ref_s    refi;             // References driven
    logic [29:0] pins, pins2;      // Port of each copy
    vpf_ref_s    refo, refo2;      // References out
    logic        bad, bad2;        // Refusal flags
    logic [29:0] e_pins, e_pins2;  // Expected ports
    vpf_ref_s    e_ref;            // Expected references
    logic        e_bad, e_bad2;    // Expected refusals
    logic [1:0]  ph;               // Bench copy of word order
    logic [31:0] got;              // Words seen by the sink
    int          mismatches = 0;
    int          check_count = 0;
    int          sent = 0;         // Active words driven
    bit          armed = 0;        // Outputs meaningful

    vpf_pixel_port dut_u
    (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .path_i     (path),
        .mode_i     (mode),
        .pix_i      (pix),
        .ref_i      (refi),
        .pins_o     (pins),
        .ref_o      (refo),
        .mode_bad_o (bad)
    );

    // Same block told its clock is too fast for single-lane modes
    vpf_pixel_port #(.CLK_MHZ(60)) dut_u2
    (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .path_i     (path),
        .mode_i     (mode),
        .pix_i      (pix),
        .ref_i      (refi),
        .pins_o     (pins2),
        .ref_o      (refo2),
        .mode_bad_o (bad2)
    );

    vpf_sink_model sink_u
    (
        .clk_sys_i (clk_sys_i),
        .pins_i    (pins),
        .ref_i     (refo),
        .words_o   (got)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and closing
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // A hang counts as a failure
    initial
    begin
        #(WD_NS);
        mismatches++;
        wrap_up();
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [35:0] seen,
                         input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference model of the pin maps
    function automatic logic [11:0] pick(input vpf_pix_s x, input int k);
        if (k == 0)
            return x.chan_a;
        if (k == 1)
            return x.chan_b;
        return x.chan_c;
    endfunction

    // w: single-lane word, c: dual-lane chroma of this clock
    function automatic logic [29:0] port_of(input logic p, input int m,
        input vpf_pix_s x, input logic [11:0] w, input logic [11:0] c);
        logic [29:0] r;
        logic [11:0] a, h, l;
        r = '0;
        a = x.chan_a;
        // Pair order AB, AC, CA, CB repeats every four modes
        h = pick(x, (m % 4 < 2) ? 0 : 2);
        l = pick(x, (m % 4 == 2) ? 0 : ((m % 4 == 1) ? 2 : 1));
        if (m == 1)
            r[19:12] = w[7:0];
        else if (m == 2)
            r[19:10] = w[9:0];
        else if (!p)
            case (m)
                3: r[19:2] = {a[7:0], 2'h0, c[7:0]};
                4: r[19:0] = {a[9:0], c[9:0]};
                5: r = {x.chan_b[7:0], 2'h0, a[7:0], 2'h0, x.chan_c[7:0], 2'h0};
                default: r = {x.chan_b[9:0], a[9:0], x.chan_c[9:0]};
            endcase
        else
            case (m)
                3: r[19:10] = w[11:2];
                4: r[19:12] = w[11:4];
                5: r[19:6] = {w[11:4], 2'h0, w[3:0]};
                6: r[19:2] = {a[7:0], 2'h0, c[7:0]};
                7: r[19:0] = {a[9:0], c[9:0]};
                8: r[19:2] = {a[9:2], 2'h0, c[9:2]};
                9: r[19:0] = {a[11:2], c[11:2]};
                10: r[19:2] = {a[11:4], 2'h0, c[11:4]};
                11: r[19:2] = {a[11:4], 2'h0, a[3:0], c[3:0]};
                12, 13, 14, 15: r[19:2] = {h[7:0], 2'h0, l[7:0]};
                default: r[19:0] = {h[9:0], l[9:0]};
            endcase
        return r;
    endfunction

    // One clock: check last word, then drive the next at the falling edge
    task automatic step(input int m, input logic p, input logic act);
        vpf_pix_s    x;
        vpf_ref_s    r;
        logic [11:0] w, c;
        logic        ok, ok2;
        int          k;
        x = {12'($urandom), 12'($urandom), 12'($urandom)};
        if ($urandom % 8 == 0)
            x = '1; // All ones shows any stray pin
        r = vpf_ref_s'(3'($urandom));
        r.active_video_or_parity = act;
        @(negedge clk_sys_i);
        if (armed)
        begin
            check("p_up", pins[29:20], e_pins[29:20]);
            check("p_hi", pins[19:10], e_pins[19:10]);
            check("p_lo", pins[9:0], e_pins[9:0]);
            check("ref", refo, e_ref);
            check("bad", bad, e_bad);
            check("pins2", pins2, e_pins2);
            check("bad2", bad2, e_bad2);
        end
        // Order restarts on the clock after blanking begins
        k = (ph == 2'h0) ? 2 : ((ph == 2'h2) ? 1 : 0);
        w = pick(x, k);
        c = ph[0] ? x.chan_b : x.chan_c;
        ok = m >= 1 && m <= (p ? 19 : 6);
        ok2 = ok && !(p && m <= 5);
        e_pins = ok ? port_of(p, m, x, w, c) : '0;
        e_pins2 = ok2 ? e_pins : '0;
        e_bad = !ok;
        e_bad2 = !ok2;
        e_ref = r;
        ph = act ? ph + 2'h1 : 2'h0;
        sent += int'(act);
        path = vpf_path_e'(p);
        mode = 5'(m);
        pix = x;
        refi = r;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int seed;
        nrst_i = 1'b0;
        path = VPF_SD_DECODE_PATH;
        mode = '0;
        pix = '0;
        refi = '0;
        ph = 2'h0;
        seed = $urandom(32'h8813);
        repeat (10) @(negedge clk_sys_i);
        check("rst_pins", pins, '0);
        check("rst_bad", bad, 1'b1);
        $display("reset test done");
        nrst_i = 1'b1;
        repeat (3) step(0, 1'b0, 1'b0);
        armed = 1;
        // Every code on both paths, each burst opened by blanking
        for (int p = 0; p < 2; p++)
            for (int m = 0; m < 32; m++)
                for (int i = 0; i < 10; i++)
                    step(m, p[0], i > 0 && ($urandom % 4) != 0);
        $display("mode sweep done");
        repeat (3) step(0, 1'b0, 1'b0);
        check("words", got, sent);
        $display("word count done");
        // Reset in mid-stream clears the port at once
        step(13, 1'b1, 1'b1);
        #1 nrst_i = 1'b0;
        #1;
        check("mid_pins", pins, '0);
        check("mid_ref", refo, '0);
        @(negedge clk_sys_i);
        nrst_i = 1'b1;
        armed = 0;
        repeat (3) step(0, 1'b0, 1'b0);
        armed = 1;
        $display("mid reset done");
        // Random mode bursts, back to back
        repeat (40)
        begin
            int m;
            int p;
            m = $urandom % 20;
            p = $urandom % 2;
            for (int i = 0; i < 8; i++)
                step(m, p[0], i > 0 && ($urandom % 5) != 0);
        end
        step(0, 1'b0, 1'b0);
        $display("random run done");
        wrap_up();
    end

endmodule // tb_top
`default_nettype wire

// ---- sim/vpf_sink_model.sv ----
/*
 * Far-side receiver of the pixel port: takes one word per pixel clock.
 * Assumes the port and references are sampled on the rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module vpf_sink_model
(
    input  wire logic              clk_sys_i,
    input  wire logic [29:0]       pins_i,
    input  wire vpf_pkg::vpf_ref_s ref_i,
    output logic [31:0]            words_o
);
    import vpf_pkg::*;

    logic [29:0] word; // Last word taken, kept for viewing

    initial words_o = 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // Pins and references taken on one edge, counting active words
    always @(posedge clk_sys_i)
    begin
        word <= pins_i;
        // Unknown never counts, so a dead port shows up
        if (ref_i.active_video_or_parity === 1'b1)
            words_o <= words_o + 32'h1;
    end

endmodule // vpf_sink_model
`default_nettype wire

// ---- src/vpf_pixel_port.sv ----
/*
 * Pixel port formatter: maps a processed pixel stream onto the 30-pin
 * parallel port at single data rate, with timing references alongside.
 * Assumes pixels and references arrive synchronous to clk_sys_i, one
 * pixel per clock, with chroma already matched to the chosen sampling.
 */
// Behaviour
// - SD 8-bit 4:2:2 interleaved on pins 19..12
// - SD 10-bit 4:2:2 interleaved on pins 19..10
// - SD 16-bit: luma 19..12, chroma 9..2
// - SD 20-bit: luma 19..10, chroma 9..0
// - SD 24-bit 4:4:4: Y, Cb, Cr upper
// - SD 30-bit 4:4:4: Y, Cb, Cr upper
// - Component 12-bit, bits 11..2 on 19..10
// - Component 12-bit, bits 11..4 on 19..12
// - Component split 12-bit: 11..4 high, 3..0 on 9..6
// - Component 16-bit: A high, B/C alternating low
// - Component 20-bit: A 9..0, B/C 9..0
// - Component split 20-bit: bits 9..2 of each
// - Component 24-bit 4:2:2: bits 11..4 both lanes
// - Component 24-bit: luma split, chroma low nibble
// - Component 24-bit 4:4:4 pairs AB, AC, CA, CB
// - Component 30-bit pairs AB, AC, CA, CB
// - A luma/green, B red, C blue
// - Unassigned pins driven low
// - One complete word per pixel clock
// - Component offers 16/20 and 24/30-bit widths
// - Syncs and data valid travel with pixels
// - Single-lane component modes only up to 54 MHz
`timescale 1ns/10ps
`default_nettype none

`include "vpf_consts.svh"

module vpf_pixel_port
#(
    parameter int CLK_MHZ = `VPF_CLK_MHZ,   // Pixel clock rate
    parameter int PORT_W  = `VPF_PORT_W     // Pins on the port
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    input  wire vpf_pkg::vpf_path_e path_i,    // Path feeding the port
    input  wire vpf_pkg::vpf_mode_t mode_i,    // Port mode of that path
    input  wire vpf_pkg::vpf_pix_s  pix_i,     // Pixel of this clock
    input  wire vpf_pkg::vpf_ref_s  ref_i,     // References of this clock
    output logic [PORT_W-1:0]       pins_o,    // Data pins 29..0
    output vpf_pkg::vpf_ref_s       ref_o,     // References, aligned
    output logic                    mode_bad_o // Mode refused, pins low
);

    import vpf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Parameter checks

    // The pin maps are fixed to a 30-pin port
    if (PORT_W != `VPF_PORT_W)
    begin : g_bad_port
        $error("vpf_pixel_port: port width must be 30");
    end

    // A clock rate of zero cannot be judged against the ceiling
    if (CLK_MHZ < 1)
    begin : g_bad_clk
        $error("vpf_pixel_port: clock rate must be positive");
    end

    ////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_n;    // Synchronously released reset

    vpf_rst_sync u_rst_sync
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .rst_n_o   (rst_n)
    );

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Channel by number: 0 A, 1 B, 2 C
    function automatic logic [`VPF_SAMPLE_W-1:0] chan_pick
    (
        input logic [1:0] sel,
        input vpf_pix_s   px
    );
        unique case (sel)
            2'h0:    chan_pick = px.chan_a;
            2'h1:    chan_pick = px.chan_b;
            default: chan_pick = px.chan_c;
        endcase
    endfunction

    // True for the single-lane component modes
    function automatic logic is_narrow(input vpf_mode_t m);
        is_narrow = (m >= VPF_M1) && (m <= VPF_M5);
    endfunction

    // Rate ceiling for single-lane component modes
    localparam logic NARROW_OK = (CLK_MHZ <= `VPF_NARROW_MAX_MHZ);

    ////////////////////////////////////////////////////////////////////
    // 4:2:2 word order

    vpf_phase_e phase;        // Current single-lane word
    vpf_phase_e next_phase;   // Word of the next clock
    logic       chb_turn;     // Dual-lane chroma: B now, else C
    logic       next_chb_turn;

    // Order Cb, Y, Cr, Y; restarts at each line while valid is low
    assign next_phase = !ref_i.active_video_or_parity ? VPF_PH_CB :
                        (phase == VPF_PH_CB) ? VPF_PH_Y0 :
                        (phase == VPF_PH_Y0) ? VPF_PH_CR :
                        (phase == VPF_PH_CR) ? VPF_PH_Y1 : VPF_PH_CB;

    // Blue difference leads every line on the chroma lane
    assign next_chb_turn = ref_i.active_video_or_parity & ~chb_turn;

    // Phase state
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase    <= VPF_PH_CB;
            chb_turn <= 1'b0;
        end
        else
        begin
            phase    <= next_phase;
            chb_turn <= next_chb_turn;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Word selection

    logic                     on_luma;  // Single lane carries luma
    logic [`VPF_SAMPLE_W-1:0] ilv;      // Single-lane word
    logic [`VPF_SAMPLE_W-1:0] chr;      // Dual-lane chroma word

    // Default carriage: A luma, B red diff, C blue diff
    assign on_luma = (phase == VPF_PH_Y0) || (phase == VPF_PH_Y1);
    assign ilv = on_luma ? pix_i.chan_a :
                 (phase == VPF_PH_CB) ? pix_i.chan_c : pix_i.chan_b;
    assign chr = chb_turn ? pix_i.chan_b : pix_i.chan_c;

    ////////////////////////////////////////////////////////////////////
    // Pin maps

    // Returns {accepted, pins}; every field not written stays low
    function automatic logic [`VPF_PORT_W:0] pin_map
    (
        input vpf_path_e                path,
        input vpf_mode_t                m,
        input vpf_pix_s                 px,
        input logic [`VPF_SAMPLE_W-1:0] iw,
        input logic [`VPF_SAMPLE_W-1:0] cw
    );
        logic [`VPF_PORT_W-1:0]   p;
        logic                     ok;
        logic [`VPF_SAMPLE_W-1:0] hw;   // 4:4:4 channel for the high lane
        logic [`VPF_SAMPLE_W-1:0] lw;   // 4:4:4 channel for the low lane
        p  = '0;
        ok = 1'b1;
        // Pair order AB, AC, CA, CB from the low mode bits
        hw = chan_pick(m[1] ? 2'h2 : 2'h0, px);
        lw = chan_pick(m[1:0] == 2'h0 ? 2'h1 :
                       m[1:0] == 2'h1 ? 2'h2 :
                       m[1:0] == 2'h2 ? 2'h0 : 2'h1, px);
        if (path == VPF_SD_DECODE_PATH)
        begin
            // Decode path: A luma, B red diff, C blue diff
            unique case (m)
                VPF_M1: p[`VPF_HI8] = iw[7:0];
                VPF_M2: p[`VPF_HI10] = iw[9:0];
                VPF_M3:
                begin
                    p[`VPF_HI8] = px.chan_a[7:0];
                    p[`VPF_LO8] = cw[7:0];
                end
                VPF_M4:
                begin
                    p[`VPF_HI10] = px.chan_a[9:0];
                    p[`VPF_LO10] = cw[9:0];
                end
                VPF_M5:
                begin
                    p[`VPF_HI8] = px.chan_a[7:0];
                    p[`VPF_LO8] = px.chan_c[7:0];
                    p[`VPF_UP8] = px.chan_b[7:0];
                end
                VPF_M6:
                begin
                    p[`VPF_HI10] = px.chan_a[9:0];
                    p[`VPF_LO10] = px.chan_c[9:0];
                    p[`VPF_UP10] = px.chan_b[9:0];
                end
                // Unknown or off: port held low
                default: ok = 1'b0;
            endcase
        end
        else
        begin
            // Component path; single-lane modes carry one word a clock
            unique case (m)
                VPF_M1: p[`VPF_HI8] = iw[7:0];
                VPF_M2: p[`VPF_HI10] = iw[9:0];
                VPF_M3: p[`VPF_HI10] = iw[11:2];
                VPF_M4: p[`VPF_HI8] = iw[11:4];
                VPF_M5:
                begin
                    p[`VPF_HI8]  = iw[11:4];
                    p[`VPF_LO4A] = iw[3:0];
                end
                VPF_M6:
                begin
                    p[`VPF_HI8] = px.chan_a[7:0];
                    p[`VPF_LO8] = cw[7:0];
                end
                VPF_M7:
                begin
                    p[`VPF_HI10] = px.chan_a[9:0];
                    p[`VPF_LO10] = cw[9:0];
                end
                VPF_M8:
                begin
                    p[`VPF_HI8] = px.chan_a[9:2];
                    p[`VPF_LO8] = cw[9:2];
                end
                VPF_M9:
                begin
                    p[`VPF_HI10] = px.chan_a[11:2];
                    p[`VPF_LO10] = cw[11:2];
                end
                VPF_M10:
                begin
                    p[`VPF_HI8] = px.chan_a[11:4];
                    p[`VPF_LO8] = cw[11:4];
                end
                VPF_M11:
                begin
                    p[`VPF_HI8]  = px.chan_a[11:4];
                    p[`VPF_LO4A] = px.chan_a[3:0];
                    p[`VPF_LO4B] = cw[3:0];
                end
                // 4:4:4 pairs, 8-bit: AB, AC, CA, CB
                VPF_M12, VPF_M13, VPF_M14, VPF_M15:
                begin
                    p[`VPF_HI8] = hw[7:0];
                    p[`VPF_LO8] = lw[7:0];
                end
                // 10-bit pairs in the same order
                VPF_M16, VPF_M17, VPF_M18, VPF_M19:
                begin
                    p[`VPF_HI10] = hw[9:0];
                    p[`VPF_LO10] = lw[9:0];
                end
                // Unknown or off: port held low
                default: ok = 1'b0;
            endcase
            // Single-lane modes refused above the rate ceiling
            if (is_narrow(m) && !NARROW_OK)
            begin
                ok = 1'b0;
            end
        end
        // A refused mode leaves every pin low
        pin_map = ok ? {1'b1, p} : {1'b0, {`VPF_PORT_W{1'b0}}};
    endfunction

    logic [`VPF_PORT_W:0]   map;        // Accept flag and pins
    logic [`VPF_PORT_W-1:0] next_pins;  // Pins of the next clock
    logic                   next_bad;   // Mode refused next clock

    assign map       = pin_map(path_i, mode_i, pix_i, ilv, chr);
    assign next_pins = map[`VPF_PORT_W-1:0];
    assign next_bad  = ~map[`VPF_PORT_W];

    ////////////////////////////////////////////////////////////////////
    // Output stage

    // Data and references share one edge so the receiver never
    // sees a pixel paired with the previous clock's syncs
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_o     <= '0;
            ref_o      <= '0;
            mode_bad_o <= 1'b1;
        end
        else
        begin
            pins_o     <= next_pins;
            ref_o      <= ref_i;
            mode_bad_o <= next_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic sd_path;  // Decode path selected
    logic cp_path;  // Component path selected
    assign sd_path = (path_i == VPF_SD_DECODE_PATH);
    assign cp_path = (path_i == VPF_COMPONENT_PATH);

    logic live;     // Outputs carry real data

    // Outputs still show reset one edge after release, so checks wait
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            live <= 1'b0;
        end
        else
        begin
            live <= 1'b1;
        end
    end

    sd_byte_lane_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        sd_path && mode_i == VPF_M1 && on_luma
        |=> pins_o[`VPF_HI8] == $past(pix_i.chan_a[7:0])
            && pins_o[11:0] == '0 && pins_o[`VPF_UP10] == '0)
        else $error("decode 8-bit lane wrong");

    sd_ten_lane_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        sd_path && mode_i == VPF_M2 && phase == VPF_PH_CB
        |=> pins_o[`VPF_HI10] == $past(pix_i.chan_c[9:0])
            && pins_o[`VPF_LO10] == '0)
        else $error("decode 10-bit lane wrong");

    sd_full_map_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        sd_path && mode_i == VPF_M6
        |=> pins_o == {$past(pix_i.chan_b[9:0]),
                       $past(pix_i.chan_a[9:0]),
                       $past(pix_i.chan_c[9:0])})
        else $error("decode 30-bit map wrong");

    cp_split_map_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        cp_path && mode_i == VPF_M5 && on_luma && NARROW_OK
        |=> pins_o[`VPF_LO4A] == $past(pix_i.chan_a[3:0])
            && pins_o[5:0] == '0 && pins_o[11:10] == '0)
        else $error("component split 12-bit wrong");

    cp_chroma_alt_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        (!ref_i.active_video_or_parity ##1
         ref_i.active_video_or_parity && cp_path && mode_i == VPF_M6)
        |=> pins_o[`VPF_LO8] == $past(pix_i.chan_c[7:0]))
        else $error("chroma lane not led by blue");

    cp_pair_map_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        cp_path && mode_i == VPF_M14
        |=> pins_o[`VPF_HI8] == $past(pix_i.chan_c[7:0])
            && pins_o[`VPF_LO8] == $past(pix_i.chan_a[7:0]))
        else $error("component C/A pair wrong");

    cp_word_rate_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        (cp_path && mode_i == VPF_M7) [*2]
        |=> pins_o[`VPF_HI10] == $past(pix_i.chan_a[9:0])
            && $past(pins_o[`VPF_HI10]) == $past(pix_i.chan_a[9:0], 2))
        else $error("component word missed a clock");

    refused_low_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        mode_bad_o |-> pins_o == '0)
        else $error("refused mode left pins driven");

    ref_align_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        $changed(ref_i) |=> ref_o == $past(ref_i))
        else $error("references not aligned");

    narrow_rate_a: assert property (
        @(posedge clk_sys_i) disable iff (!live)
        cp_path && is_narrow(mode_i) |=> mode_bad_o == !NARROW_OK)
        else $error("rate ceiling not applied");

endmodule // vpf_pixel_port

`default_nettype wire

// ---- src/vpf_rst_sync.sv ----
/*
 * Reset release synchroniser for the pixel port formatter.
 * Assumes an active-low asynchronous reset and one free-running clock.
 */
`timescale 1ns/10ps
`default_nettype none

module vpf_rst_sync
(
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    output logic      rst_n_o
);

    logic meta_n;   // First stage, read only by the second

    // Assert at once, release after two edges
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_n  <= 1'b0;
            rst_n_o <= 1'b0;
        end
        else
        begin
            meta_n  <= 1'b1;
            rst_n_o <= meta_n;
        end
    end

endmodule // vpf_rst_sync

`default_nettype wire
